// [svor_pkg.sv]
// ==========================================================================
// shared constants
package svor_pkg;

  // ========================================================================
  // clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_PERIOD_NS = 100;  // link limit is 20 MHz
  localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PKT_GAP_NS    = 4000;
  localparam int PKT_GAP_CYC   = (PKT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ========================================================================
  // packet layout, msb first
  localparam int NUM_CH             = 2;
  localparam int PKT_W              = 8;
  localparam int CHANNEL_SELECT_BIT = 7;
  localparam int SIGN_BIT           = 6;
  localparam int MAG_LSB            = 1;
  localparam int MAG_W              = 5;
  localparam logic [3:0] PKT_BITS   = 4'h8;
  localparam logic [3:0] CNT_SAT    = 4'h9;
  localparam logic [2:0] SYNC_RST   = 3'h2;   // {mosi, chip select, sck}

  // ========================================================================
  // pwm mode configuration bits
  localparam int MODE_STEP_BIT   = 2;  // 1: 10 mV per step, 0: 5 mV
  localparam int MODE_TRACK_BIT  = 3;  // 1: fault limits follow offset
  localparam int MODE_IGNORE_BIT = 4;  // 1: channel select bit ignored
  localparam int STEP_SMALL_MV   = 5;
  localparam int STEP_BIG_MV     = 10;

  // ========================================================================
  // controller register map (byte addresses)
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] REG_TXDATA   = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS   = 8'h08;
  localparam logic [AXI_AW-1:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h10;
  localparam int CTRL_RAW_BIT  = 0;
  localparam int CTRL_NB_LSB   = 4;
  localparam int IRQ_W         = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ========================================================================
  // controller states
  typedef enum logic [5:0] {
    SVOR_IDLE = 6'h01,
    SVOR_LEAD = 6'h02,
    SVOR_HIGH = 6'h04,
    SVOR_LOW  = 6'h08,
    SVOR_TAIL = 6'h10,
    SVOR_GAP  = 6'h20
  } svor_state_e;

endpackage : svor_pkg

// [svor_if.sv]
`timescale 1ns/100ps
// ==========================================================================
// serial offset link
interface svor_if;
  logic sck;
  logic serial_chip_select_n;
  logic mosi;
  logic serial_error_flag_n_out;
  logic serial_error_flag_n_oe;
  logic serial_error_flag_n;

  // flag line pull-up
  assign serial_error_flag_n = serial_error_flag_n_oe ? serial_error_flag_n_out : 1'b1;

  modport dev (
    input  sck,
    input  serial_chip_select_n,
    input  mosi,
    output serial_error_flag_n_out,
    output serial_error_flag_n_oe
  );

  modport host (
    output sck,
    output serial_chip_select_n,
    output mosi,
    input  serial_error_flag_n
  );
endinterface : svor_if

// [svor_dev.sv]
`timescale 1ns/100ps
module svor_dev #(
  parameter int unsigned SP_W = 16
) (
  // clock, reset, enable
  input  wire logic                                      clk,
  input  wire logic                                      arst_n,
  input  wire logic                                      ce,
  // serial link
  svor_if.dev                                            lnk,
  // management side
  input  wire logic [svor_pkg::NUM_CH-1:0][7:0]          pwm_mode_config,
  input  wire logic [svor_pkg::NUM_CH-1:0]               rail_on,
  input  wire logic                                      soft_reset_command,
  input  wire logic                                      restore_pulse,
  // programmed levels in mV
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     output_setpoint,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     margin_high,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     margin_low,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     fault_ov,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     fault_uv,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     warn_ov,
  input  wire logic [svor_pkg::NUM_CH-1:0][SP_W-1:0]     warn_uv,
  // adjusted levels in mV
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_setpoint,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_margin_high,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_margin_low,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_fault_ov,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_fault_uv,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_warn_ov,
  output logic      [svor_pkg::NUM_CH-1:0][SP_W-1:0]     adj_warn_uv,
  // status towards management
  output logic      [svor_pkg::NUM_CH-1:0][7:0]          offset_readback,
  output logic                                           packet_ok,
  output logic                                           packet_err
);
  import svor_pkg::*;

  // ========================================================================
  // elaboration checks
  if (SP_W < 12) begin : g_chk
    $error("SP_W too narrow for the largest offset");
  end

  // ========================================================================
  // helpers

  // signed offset in mV
  function automatic logic [SP_W-1:0] off_mv(input logic sgn, input logic [MAG_W-1:0] mag,
                                             input logic big);
    logic [SP_W-1:0] m;
    m = SP_W'(mag) * (big ? SP_W'(STEP_BIG_MV) : SP_W'(STEP_SMALL_MV));
    return sgn ? (~m + SP_W'(1)) : m;
  endfunction : off_mv

  // ========================================================================
  // link input sampling

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [1:0] prev_ff;
  logic       sck_s;
  logic       cs_s;
  logic       mosi_s;
  logic       sck_rise;
  logic       cs_fall;
  logic       cs_rise;

  // two-stage synchronisers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      prev_ff  <= SYNC_RST[1:0];
    end else if (ce) begin
      sync1_ff <= {lnk.mosi, lnk.serial_chip_select_n, lnk.sck};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[1:0];
    end
  end

  // edges; a 20 MHz sck still gives 2+ samples a phase
  assign sck_s    = sync2_ff[0];
  assign cs_s     = sync2_ff[1];
  assign mosi_s   = sync2_ff[2];
  assign sck_rise = sck_s & ~prev_ff[0];
  assign cs_fall  = ~cs_s & prev_ff[1];
  assign cs_rise  = cs_s & ~prev_ff[1];

  // ========================================================================
  // packet capture

  logic [3:0]       cnt_ff;
  logic [PKT_W-1:0] shreg_ff;
  logic             bad;
  logic             good;

  // host moves data on the falling edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff   <= 4'h0;
      shreg_ff <= '0;
    end else if (ce) begin
      if (cs_fall) begin
        cnt_ff <= 4'h0;
      end else if (sck_rise && !cs_s) begin
        shreg_ff <= {shreg_ff[PKT_W-2:0], mosi_s};
        if (cnt_ff != CNT_SAT) begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end

  // judged once, at chip select release
  assign bad  = cs_rise & ((cnt_ff != PKT_BITS) | ~(^shreg_ff));
  assign good = cs_rise & ~bad;

  // ========================================================================
  // error flag and events

  logic err_ff;

  // low from a bad release to the next fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_ff <= 1'b0;
    end else if (ce) begin
      if (bad) begin
        err_ff <= 1'b1;
      end else if (cs_fall) begin
        err_ff <= 1'b0;
      end
    end
  end

  // open drain: only pulls low
  assign lnk.serial_error_flag_n_out = 1'b0;
  assign lnk.serial_error_flag_n_oe  = err_ff;

  // one-cycle reports
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      packet_ok  <= 1'b0;
      packet_err <= 1'b0;
    end else if (ce) begin
      packet_ok  <= good;
      packet_err <= bad;
    end
  end

  // ========================================================================
  // stored offsets

  logic [NUM_CH-1:0]            sgn_ff;
  logic [NUM_CH-1:0][MAG_W-1:0] mag_ff;
  logic                         ignore_any;
  logic                         tgt;
  logic                         clr_all;

  // ignore mode: channel 0 wins if both run
  assign ignore_any = pwm_mode_config[0][MODE_IGNORE_BIT] |
                      pwm_mode_config[1][MODE_IGNORE_BIT];
  assign tgt        = ignore_any ? ~rail_on[0] : shreg_ff[CHANNEL_SELECT_BIT];
  assign clr_all    = soft_reset_command | restore_pulse;

  // a clear beats a packet in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sgn_ff <= '0;
      mag_ff <= '0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!rail_on[c] || clr_all) begin
          sgn_ff[c] <= 1'b0;
          mag_ff[c] <= '0;
        end else if (good && (tgt == c[0])) begin
          sgn_ff[c] <= shreg_ff[SIGN_BIT];
          mag_ff[c] <= shreg_ff[MAG_LSB +: MAG_W];
        end
      end
    end
  end

  // ========================================================================
  // applied levels

  logic [NUM_CH-1:0][SP_W-1:0] off_w;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      off_w[c] = off_mv(sgn_ff[c], mag_ff[c], pwm_mode_config[c][MODE_STEP_BIT]);
    end
  end

  // sums wrap at the level width
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adj_setpoint    <= '0;
      adj_margin_high <= '0;
      adj_margin_low  <= '0;
      adj_fault_ov    <= '0;
      adj_fault_uv    <= '0;
      adj_warn_ov     <= '0;
      adj_warn_uv     <= '0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        adj_setpoint[c]    <= output_setpoint[c] + off_w[c];
        adj_margin_high[c] <= margin_high[c] + off_w[c];
        adj_margin_low[c]  <= margin_low[c] + off_w[c];
        if (pwm_mode_config[c][MODE_TRACK_BIT]) begin
          adj_fault_ov[c] <= fault_ov[c] + off_w[c];
          adj_fault_uv[c] <= fault_uv[c] + off_w[c];
        end else begin
          adj_fault_ov[c] <= fault_ov[c];
          adj_fault_uv[c] <= fault_uv[c];
        end
        adj_warn_ov[c] <= warn_ov[c];
        adj_warn_uv[c] <= warn_uv[c];
      end
    end
  end

  // ========================================================================
  // readback in steps, two's complement
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_readback <= '0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        offset_readback[c] <= sgn_ff[c] ? (8'h00 - {3'h0, mag_ff[c]}) : {3'h0, mag_ff[c]};
      end
    end
  end

endmodule : svor_dev

// [svor_host.sv]
`timescale 1ns/100ps
// ==========================================================================
// link controller: one packet per data write made while idle
module svor_host #(
  parameter int unsigned HALF_CYC = svor_pkg::SCK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        ce,
  // axi4-lite slave
  input  wire logic [svor_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [svor_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // interrupt
  output logic                             irq,
  // serial link
  svor_if.host                             lnk
);
  import svor_pkg::*;

  // ========================================================================
  // elaboration checks
  if (HALF_CYC < 3 || HALF_CYC > 65535) begin : g_chk
    $error("HALF_CYC out of range");
  end
  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [15:0] GAP_M1  = 16'(PKT_GAP_CYC - 1);

  // ========================================================================
  // register bus
  svor_state_e        st_ff;
  logic               raw_ff;
  logic [3:0]         nb_ff;
  logic [IRQ_W-1:0]   stat_ff;
  logic [IRQ_W-1:0]   mask_ff;
  logic               last_err_ff;
  logic               wr_hs;
  logic               rd_hs;
  logic               busy;
  logic               go;
  logic [IRQ_W-1:0]   ev_set;
  logic [IRQ_W-1:0]   w1c;
  logic [1:0]         err_sync_ff;

  assign busy          = (st_ff != SVOR_IDLE);
  assign wr_hs         = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_hs;
  assign s_axi_wready  = wr_hs;
  assign rd_hs         = ce & s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_hs;
  assign go  = wr_hs && (s_axi_awaddr == REG_TXDATA) && s_axi_wstrb[0] && !busy;
  assign w1c = (wr_hs && (s_axi_awaddr == REG_IRQ_STAT) && s_axi_wstrb[0]) ?
               s_axi_wdata[IRQ_W-1:0] : '0;

  // writes; a busy data write gets slverr
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_ff       <= 1'b0;
      nb_ff        <= 4'h0;
      mask_ff      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_hs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        unique case (s_axi_awaddr)
          REG_CTRL: begin
            if (s_axi_wstrb[0]) begin
              raw_ff <= s_axi_wdata[CTRL_RAW_BIT];
              nb_ff  <= s_axi_wdata[CTRL_NB_LSB +: 4];
            end
          end
          REG_TXDATA:   if (busy) s_axi_bresp <= RESP_SLVERR;
          REG_IRQ_STAT: ;
          REG_IRQ_MASK: if (s_axi_wstrb[0]) mask_ff <= s_axi_wdata[IRQ_W-1:0];
          default:      s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reads answer one cycle later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          REG_CTRL:     s_axi_rdata <= {24'h0, nb_ff, 3'h0, raw_ff};
          REG_TXDATA:   s_axi_rdata <= 32'h0;
          REG_STATUS:   s_axi_rdata <= {29'h0, err_sync_ff[1], last_err_ff, busy};
          REG_IRQ_STAT: s_axi_rdata <= {30'h0, stat_ff};
          REG_IRQ_MASK: s_axi_rdata <= {30'h0, mask_ff};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky events; set beats clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= '0;
      irq     <= 1'b0;
    end else if (ce) begin
      stat_ff <= (stat_ff & ~w1c) | ev_set;
      irq     <= |(stat_ff & mask_ff);
    end
  end

  // ========================================================================
  // link sequencer
  logic [15:0]      tmr_ff;
  logic [3:0]       bits_ff;
  logic [PKT_W-1:0] tx_ff;
  logic             sck_ff;
  logic             cs_n_ff;

  // flag pin is asynchronous: two stages
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_sync_ff <= 2'h3;
    end else if (ce) begin
      err_sync_ff <= {err_sync_ff[0], lnk.serial_error_flag_n};
    end
  end

  assign lnk.sck                  = sck_ff;
  assign lnk.serial_chip_select_n = cs_n_ff;
  assign lnk.mosi                 = tx_ff[PKT_W-1];
  assign ev_set = (st_ff == SVOR_GAP && tmr_ff == 16'h0) ?
                  {~err_sync_ff[1], 1'b1} : '0;

  // 4 us gap after each frame, flag read at its end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff       <= SVOR_IDLE;
      tmr_ff      <= 16'h0;
      bits_ff     <= 4'h0;
      tx_ff       <= '0;
      sck_ff      <= 1'b0;
      cs_n_ff     <= 1'b1;
      last_err_ff <= 1'b0;
    end else if (ce) begin
      if (tmr_ff != 16'h0) begin
        tmr_ff <= tmr_ff - 16'h1;
      end else begin
        unique case (st_ff)
          SVOR_IDLE: if (go) begin
            tx_ff   <= raw_ff ? s_axi_wdata[PKT_W-1:0] :
                       {s_axi_wdata[PKT_W-1:1], ~(^s_axi_wdata[PKT_W-1:1])};
            bits_ff <= (nb_ff == 4'h0) ? PKT_BITS : nb_ff;
            cs_n_ff <= 1'b0;
            tmr_ff  <= HALF_M1;
            st_ff   <= SVOR_LEAD;
          end
          SVOR_LEAD, SVOR_LOW: begin
            sck_ff <= 1'b1;
            tmr_ff <= HALF_M1;
            st_ff  <= SVOR_HIGH;
          end
          SVOR_HIGH: begin
            sck_ff  <= 1'b0;
            tx_ff   <= {tx_ff[PKT_W-2:0], 1'b0};
            bits_ff <= bits_ff - 4'h1;
            tmr_ff  <= HALF_M1;
            st_ff   <= (bits_ff == 4'h1) ? SVOR_TAIL : SVOR_LOW;
          end
          SVOR_TAIL: begin
            cs_n_ff <= 1'b1;
            tmr_ff  <= GAP_M1;
            st_ff   <= SVOR_GAP;
          end
          SVOR_GAP: begin
            last_err_ff <= ~err_sync_ff[1];
            st_ff       <= SVOR_IDLE;
          end
          default: st_ff <= SVOR_IDLE;
        endcase
      end
    end
  end

endmodule : svor_host

// [svor_asserts.sv]
`timescale 1ns/100ps
// ==========================================================================
// link checker
module svor_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link wires
  input wire logic sck,
  input wire logic serial_chip_select_n,
  input wire logic mosi,
  input wire logic serial_error_flag_n_out,
  input wire logic serial_error_flag_n_oe,
  input wire logic serial_error_flag_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] n_bits_ff;
  logic       par_ff;
  logic       sck_q_ff;
  logic [8:0] gap_ff;
  logic       bad;
  // bit count and parity of the frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q_ff  <= 1'b0;
      n_bits_ff <= 4'h0;
      par_ff    <= 1'b0;
    end else begin
      sck_q_ff <= sck;
      if (serial_chip_select_n) begin
        n_bits_ff <= 4'h0;
        par_ff    <= 1'b0;
      end else if (sck && !sck_q_ff) begin
        n_bits_ff <= n_bits_ff + 4'h1;
        par_ff    <= par_ff ^ mosi;
      end
    end
  end
  // idle cycles; starts full so frame one is free
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff <= 9'h190;
    end else if (!serial_chip_select_n) begin
      gap_ff <= 9'h000;
    end else if (gap_ff != 9'h190) begin
      gap_ff <= gap_ff + 9'h001;
    end
  end
  assign bad = (n_bits_ff != 4'h8) || !par_ff;
  a_flag_pulls_low: assert property (serial_error_flag_n_oe |-> !serial_error_flag_n_out)
    else $error("flag driven high");
  a_sck_idle_low: assert property (serial_chip_select_n |-> !sck)
    else $error("sck high outside frame");
  a_mosi_steady: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  a_flag_on_bad: assert property ($rose(serial_chip_select_n) && bad |-> ##[1:6] serial_error_flag_n_oe)
    else $error("bad frame not flagged");
  a_flag_quiet_good: assert property ($rose(serial_chip_select_n) && !bad |=> !serial_error_flag_n_oe [*6])
    else $error("good frame flagged");
  a_flag_holds: assert property (serial_error_flag_n_oe && serial_chip_select_n |=> serial_error_flag_n_oe)
    else $error("flag dropped early");
  a_flag_clears: assert property ($fell(serial_chip_select_n) |-> ##[1:5] serial_error_flag_n)
    else $error("flag not cleared");
  a_sck_half_min: assert property ($rose(sck) |-> sck [*5])
    else $error("sck high phase too short");
  a_frame_gap: assert property ($fell(serial_chip_select_n) |-> gap_ff == 9'h190)
    else $error("frame gap too short");
endmodule : svor_asserts

// [spi_vout_offset_receiver_test.sv]
`timescale 1ns/100ps
// ==========================================================================
// bench: both ends back to back
module spi_vout_offset_receiver_test;
  import svor_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, one = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rail = 2'h3;
  logic soft_rst = 1'b0, restore = 1'b0, p_ok, p_err;
  logic [1:0][7:0] pm = 16'h0, rb;
  logic [1:0][15:0] sp = {2{16'h03e8}}, mh = {2{16'h0400}}, ml = {2{16'h03d0}};
  logic [1:0][15:0] fov = {2{16'h0500}}, fuv = {2{16'h0300}}, wov = {2{16'h0480}};
  logic [1:0][15:0] wuv = {2{16'h0350}}, a_sp, a_mh, a_ml, a_fov, a_fuv, a_wov, a_wuv;
  int n_errors = 0, compares = 0, n_ok = 0, n_bad = 0;
  svor_if lnk ();
  svor_host i_svor_host (.clk(clk), .arst_n(arst_n), .ce(one), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(one),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(one), .irq(irq), .lnk(lnk.host));
  svor_dev #(.SP_W(16)) i_svor_dev (.clk(clk), .arst_n(arst_n), .ce(one), .lnk(lnk.dev),
    .pwm_mode_config(pm), .rail_on(rail), .soft_reset_command(soft_rst),
    .restore_pulse(restore), .output_setpoint(sp), .margin_high(mh), .margin_low(ml),
    .fault_ov(fov), .fault_uv(fuv), .warn_ov(wov), .warn_uv(wuv), .adj_setpoint(a_sp),
    .adj_margin_high(a_mh), .adj_margin_low(a_ml), .adj_fault_ov(a_fov), .adj_fault_uv(a_fuv),
    .adj_warn_ov(a_wov), .adj_warn_uv(a_wuv), .offset_readback(rb), .packet_ok(p_ok),
    .packet_err(p_err));
  svor_asserts i_svor_asserts (.clk(clk), .arst_n(arst_n), .sck(lnk.sck),
    .serial_chip_select_n(lnk.serial_chip_select_n), .mosi(lnk.mosi),
    .serial_error_flag_n_out(lnk.serial_error_flag_n_out),
    .serial_error_flag_n_oe(lnk.serial_error_flag_n_oe),
    .serial_error_flag_n(lnk.serial_error_flag_n));
  // 100 MHz bench clock
  always #5 clk = ~clk;
  // report pulse counts
  always @(posedge clk) n_ok += (p_ok === 1'b1);
  always @(posedge clk) n_bad += (p_err === 1'b1);
  // ========================================================================
  // shared tasks
  task automatic stop_test(input bit hung);
    if (hung) n_errors++;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // bready and rready are tied high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready) && ++i < 50);
    s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1 && ++i < 100);
    if (i >= 100) stop_test(1);
    chk("bresp", s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int i = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1 && ++i < 50);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1 && ++i < 100);
    if (i >= 100) stop_test(1);
    rdat = s_axi_rdata;
    chk("rresp", s_axi_rresp, er);
  endtask : rd
  // send one frame, then poll busy
  task automatic snd(input logic [7:0] c, input logic [7:0] d);
    int k;
    wr(REG_CTRL, {24'h0, c}, RESP_OKAY);
    wr(REG_TXDATA, {24'h0, d}, RESP_OKAY);
    for (k = 0; k < 100; k++) begin
      rd(REG_STATUS, RESP_OKAY);
      if (rdat[0] === 1'b0) break;
      repeat (20) @(posedge clk);
    end
    if (k == 100) stop_test(1);
  endtask : snd
  // ========================================================================
  // scenarios
  task automatic t_reset;
    chk("readback", rb, 16'h0);
    chk("flag line", lnk.serial_error_flag_n, 1'b1);
    rd(8'h14, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset
  task automatic t_values;
    snd(8'h00, 8'h06); // channel 0, +3, 5 mV steps
    chk("irq masked", irq, 1'b0);
    rd(REG_IRQ_STAT, RESP_OKAY);
    chk("irq stat", rdat[1:0], 2'h1);
    wr(REG_IRQ_MASK, 32'h3, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq raised", irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'b0);
    pm[1] <= 8'h04;
    snd(8'h00, 8'hfe); // channel 1, -31, 10 mV steps
    chk("rb0", rb[0], 8'h03);
    chk("rb1", rb[1], 8'he1);
    chk("sp0", a_sp[0], 16'h03f7);
    chk("mh0", a_mh[0], 16'h040f);
    chk("sp1", a_sp[1], 16'h02b2);
    chk("ml1", a_ml[1], 16'h029a);
    chk("fov abs", a_fov[1], 16'h0500);
    pm[1] <= 8'h0c;
    repeat (3) @(posedge clk);
    chk("fov track", a_fov[1], 16'h03ca);
    chk("wov", a_wov[1], 16'h0480);
    chk("wuv", a_wuv[0], 16'h0350);
    $display("test values done");
  endtask : t_values
  task automatic t_errors;
    wr(REG_IRQ_STAT, 32'h3, RESP_OKAY);
    snd(8'h01, 8'h06); // raw byte with even parity
    chk("flag parity", lnk.serial_error_flag_n, 1'b0);
    rd(REG_STATUS, RESP_OKAY);
    chk("status err", rdat[1], 1'b1);
    chk("rb kept", rb, 16'he103);
    repeat (50) @(posedge clk);
    chk("flag held", lnk.serial_error_flag_n, 1'b0);
    snd(8'h70, 8'h02); // seven bits only
    chk("flag count", lnk.serial_error_flag_n, 1'b0);
    chk("rb kept2", rb, 16'he103);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(REG_TXDATA, 32'h04, RESP_OKAY);
    wr(REG_TXDATA, 32'h04, RESP_SLVERR);
    repeat (500) @(posedge clk);
    chk("flag cleared", lnk.serial_error_flag_n, 1'b1);
    chk("rb0 two", rb[0], 8'h02);
    $display("test errors done");
  endtask : t_errors
  task automatic t_ignore;
    pm[1] <= 8'h10;
    snd(8'h00, 8'h88); // channel_select_bit 1, +4, lands on channel_select_bit 0
    chk("ign rb", rb, 16'he104);
    chk("ign sp0", a_sp[0], 16'h03fc);
    pm[1] <= 8'h00;
    $display("test ignore done");
  endtask : t_ignore
  task automatic t_clear;
    rail <= 2'h2;
    repeat (3) @(posedge clk);
    chk("rail off", rb, 16'he100);
    rail <= 2'h3;
    soft_rst <= 1'b1;
    repeat (3) @(posedge clk);
    soft_rst <= 1'b0;
    chk("soft reset", rb, 16'h0);
    snd(8'h00, 8'h82);
    chk("rb1 set", rb[1], 8'h01);
    restore <= 1'b1;
    @(posedge clk);
    restore <= 1'b0;
    repeat (3) @(posedge clk);
    chk("restore", rb, 16'h0);
    chk("pulses", {n_ok[7:0], n_bad[7:0]}, 16'h0502);
    $display("test clear done");
  endtask : t_clear
  // ========================================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_values();
    t_errors();
    t_ignore();
    t_clear();
    stop_test(0);
  end
endmodule : spi_vout_offset_receiver_test
